// file: common/rom_ram_io_consts.vh
// Purpose: constants for the ROM/RAM/I/O bus decoder
// Assumes: 12 address lines, three chip selects, byte data bus
// Notes:   decode masks are fixed options set here as require-high and care bits
// Overview of operation
// - Initialise input low clears all registers to zero, except output-only port set high, counter and shifter.
// - Reset makes bidirectional lines inputs and drives output-only port high.
// - Reset leaves counter, shifter and interrupts disabled until software enables them.
// - Data bus drivers stay off except while selected for a host read.
// - Direction high reads from the device; direction low writes into it.
// - All data bus transfers are timed by the phase-two clock.
// - Each first and second port line has its own direction bit.
// - Expanded variant adds an output-only 8-bit port and input-only 4-bit port.
// - Output lines drive high and low; input lines float.
// - Seventh second-port line as interrupt output only pulls low.
// - Bits 0-10 pick a ROM byte; bit 11 and selects must match.
// - Bits 0-6 pick a RAM byte; bits 7-11 and selects must match.
// - Bits 0-3 pick the I/O function; bits 4-11 and selects must match.
// - Each decode position is fixed as high, low or ignored.
// - Each chip select shares a port line; a select line is no port line.
// - 40-pin prototype: no ROM, selects ignored, fixed RAM and I/O patterns.
// - 52-pin prototype uses third select; ROM when it and bit 11 high.
// - Prototype RAM ignores address bit 8, mirroring into pages zero and one.
// - I/O operation chosen by low four address bits and direction together.
// - I/O 0-3 port data, 4-7 counter and latch accesses.
// - I/O 8-C serial, flags, enables, controls; D and E direction registers.
`ifndef ROM_RAM_IO_CONSTS_VH
`define ROM_RAM_IO_CONSTS_VH

// Decode variant: 0 masked, 1 forty-pin prototype, 2 fifty-two-pin prototype
`define VARIANT_MASKED       2'h0
`define VARIANT_PROTO_40     2'h1
`define VARIANT_PROTO_52     2'h2

// Match vectors ordered {cs3, cs2, cs1, a11..a0}; care bit set means compared
`define ROM_CARE             15'h0800
`define ROM_HIGH             15'h0800
`define RAM_CARE             15'h0F80
`define RAM_HIGH             15'h0000
`define IO_CARE              15'h0FF0
`define IO_HIGH              15'h0700

// Prototype patterns on a11..a4
`define PROTO_RAM_CARE       12'h0E80
`define PROTO_RAM_HIGH       12'h0000
`define PROTO_IO_CARE        12'h0FF0
`define PROTO_IO_HIGH        12'h0700

// Chip select use on shared lines: bit0 line b4, bit1 line b5, bit2 line d2
`define CS_USE_DEFAULT       3'h0

// I/O function offsets
`define IO_PORT_A            4'h0
`define IO_PORT_B            4'h1
`define IO_PORT_C            4'h2
`define IO_PORT_D            4'h3
`define IO_CNT_LO            4'h4
`define IO_CNT_HI            4'h5
`define IO_LATCH_LO          4'h6
`define IO_LATCH_HI          4'h7
`define IO_SERIAL            4'h8
`define IO_IRQ_FLAG          4'h9
`define IO_IRQ_ENABLE        4'hA
`define IO_AUX_CTRL          4'hB
`define IO_PERIPH_CTRL       4'hC
`define IO_DIR_A             4'hD
`define IO_DIR_B             4'hE

// Reset values
`define RST_BYTE             8'h00
`define RST_PORT_C           8'hFF
`define RST_WORD7            7'h00

// Second port line used as the interrupt request output
`define IRQ_LINE_BIT         6

`endif

// file: rtl/addr_match.v
// Purpose: area decode of address and chip selects for one variant
// Assumes: inputs already synchronous to the phase-two clock
// Notes:   purely combinational; masks are fixed options from the header
`timescale 1ns/1ps
`include "rom_ram_io_consts.vh"

module addr_match #(
    parameter [1:0] VARIANT = `VARIANT_MASKED
) (
    input  wire [11:0] addr,
    input  wire [2:0]  sel,
    output reg         rom_hit,
    output reg         ram_hit,
    output reg         io_hit
);

    // Masked compare: care bits must equal required level
    function match;
        input [14:0] vec;
        input [14:0] care;
        input [14:0] high;
        begin
            match = ((vec ^ high) & care) == 15'h0000;
        end
    endfunction

    wire [14:0] vec = {sel, addr};

    // Pick decode by variant
    always @* begin
        rom_hit = 1'b0;
        ram_hit = 1'b0;
        io_hit  = 1'b0;
        case (VARIANT)
            `VARIANT_PROTO_40: begin
                // No ROM; selects ignored; bit 8 ignored for RAM
                ram_hit = match({3'h0, addr}, {3'h0, `PROTO_RAM_CARE},
                                {3'h0, `PROTO_RAM_HIGH});
                io_hit  = match({3'h0, addr}, {3'h0, `PROTO_IO_CARE},
                                {3'h0, `PROTO_IO_HIGH});
            end
            `VARIANT_PROTO_52: begin
                rom_hit = sel[2] & addr[11];
                ram_hit = ~sel[2] & match({3'h0, addr}, {3'h0, `PROTO_RAM_CARE},
                                          {3'h0, `PROTO_RAM_HIGH});
                io_hit  = ~sel[2] & match({3'h0, addr}, {3'h0, `PROTO_IO_CARE},
                                          {3'h0, `PROTO_IO_HIGH});
            end
            default: begin
                rom_hit = match(vec, `ROM_CARE, `ROM_HIGH);
                ram_hit = match(vec, `RAM_CARE, `RAM_HIGH) & ~rom_hit;
                io_hit  = match(vec, `IO_CARE, `IO_HIGH) & ~rom_hit & ~ram_hit;
            end
        endcase
    end

endmodule

// file: rtl/rom_ram_io_bus_decode.v
// Purpose: host bus port, area decode and register file of ROM/RAM/I/O part
// Assumes: ref_clk stands for the phase-two clock; host bus synchronous to it
// Notes:   counter, serial, edge and handshake internals are outside this block
`timescale 1ns/1ps
`include "rom_ram_io_consts.vh"

module rom_ram_io_bus_decode #(
    parameter [1:0] VARIANT = `VARIANT_MASKED,
    parameter [2:0] CS_USE  = `CS_USE_DEFAULT
) (
    input  wire        ref_clk,
    input  wire        arst_n,
    input  wire        clk_en,
    input  wire        init_low_input_n,
    input  wire [11:0] addr,
    input  wire        read_not_write,
    input  wire [7:0]  data_in,
    output reg  [7:0]  data_out,
    output wire        data_oe,
    input  wire [7:0]  first_port_lines_in,
    output wire [7:0]  first_port_lines_out,
    output wire [7:0]  first_port_lines_oe,
    input  wire [6:0]  second_port_lines_in,
    output wire [6:0]  second_port_lines_out,
    output wire [6:0]  second_port_lines_oe,
    output wire [7:0]  output_only_lines,
    input  wire [3:0]  input_only_lines,
    input  wire        irq_pending,
    input  wire [15:0] counter_value,
    input  wire [7:0]  serial_read_data,
    input  wire [6:0]  irq_flag_value,
    output reg         counter_load,
    output reg  [15:0] counter_latch,
    output reg         serial_write,
    output reg  [7:0]  serial_write_data,
    output reg         flag_clear,
    output reg  [6:0]  flag_clear_mask,
    output reg         port_a_access,
    output reg         serial_access,
    output reg         counter_lo_read,
    output reg         upper_latch_write,
    output reg  [7:0]  aux_control,
    output reg  [7:0]  periph_control,
    output reg  [6:0]  irq_enable,
    output wire        rom_sel,
    output wire [10:0] rom_addr,
    input  wire [7:0]  rom_data,
    output wire [3:0]  input_only_sync
);

    // Three-stage pin synchronisers; change accepted when stages two and three agree
    reg  [7:0] pa_s1_q, pa_s2_q, pa_s3_q, pa_q;
    reg  [6:0] pb_s1_q, pb_s2_q, pb_s3_q, pb_q;
    reg  [3:0] pd_s1_q, pd_s2_q, pd_s3_q, pd_q;
    reg        rs_s1_q, rs_s2_q, rs_s3_q, rs_q;

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pa_s1_q <= 8'h00; pa_s2_q <= 8'h00; pa_s3_q <= 8'h00; pa_q <= 8'h00;
            pb_s1_q <= 7'h00; pb_s2_q <= 7'h00; pb_s3_q <= 7'h00; pb_q <= 7'h00;
            pd_s1_q <= 4'h0;  pd_s2_q <= 4'h0;  pd_s3_q <= 4'h0;  pd_q <= 4'h0;
            rs_s1_q <= 1'b0;  rs_s2_q <= 1'b0;  rs_s3_q <= 1'b0;  rs_q <= 1'b0;
        end else if (clk_en) begin
            pa_s1_q <= first_port_lines_in;
            pa_s2_q <= pa_s1_q;
            pa_s3_q <= pa_s2_q;
            pa_q    <= (pa_s2_q & pa_s3_q) | (pa_q & (pa_s2_q ^ pa_s3_q));
            pb_s1_q <= second_port_lines_in;
            pb_s2_q <= pb_s1_q;
            pb_s3_q <= pb_s2_q;
            pb_q    <= (pb_s2_q & pb_s3_q) | (pb_q & (pb_s2_q ^ pb_s3_q));
            pd_s1_q <= input_only_lines;
            pd_s2_q <= pd_s1_q;
            pd_s3_q <= pd_s2_q;
            pd_q    <= (pd_s2_q & pd_s3_q) | (pd_q & (pd_s2_q ^ pd_s3_q));
            rs_s1_q <= init_low_input_n;
            rs_s2_q <= rs_s1_q;
            rs_s3_q <= rs_s2_q;
            if (rs_s2_q == rs_s3_q) begin
                rs_q <= rs_s2_q;
            end
        end
    end

    assign input_only_sync = pd_q;

    // Chip select lines, always taken from shared port lines b4, b5 and d2, whatever CS_USE chooses
    wire [2:0] sel = {pd_q[2], pb_q[5], pb_q[4]};

    wire rom_hit, ram_hit, io_hit;

    addr_match #(
        .VARIANT (VARIANT)
    ) u_match (
        .addr    (addr),
        .sel     (sel),
        .rom_hit (rom_hit),
        .ram_hit (ram_hit),
        .io_hit  (io_hit)
    );

    wire       in_reset = ~rs_q;
    wire [3:0] io_fn    = addr[3:0];
    wire       wr_io    = io_hit & ~read_not_write & ~in_reset;
    wire       rd_io    = io_hit & read_not_write & ~in_reset;

    assign rom_sel  = rom_hit & read_not_write;
    assign rom_addr = addr[10:0];

    // Decoded one-hot function strobe helper
    function is_fn;
        input [3:0] fn;
        input [3:0] want;
        begin
            is_fn = (fn == want);
        end
    endfunction

    // RAM kept in local array; contents survive reset
    reg [7:0] ram_mem [0:127];

    always @(posedge ref_clk) begin
        if (clk_en && ram_hit && !read_not_write && !in_reset) begin
            ram_mem[addr[6:0]] <= data_in;
        end
    end

    // Registers cleared by the initialise input, all but serial_write_data and port_c_q, which is set high
    reg [7:0] port_a_q, port_c_q, dir_a_q;
    reg [6:0] port_b_q, dir_b_q;

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            port_a_q          <= `RST_BYTE;
            port_b_q          <= `RST_WORD7;
            port_c_q          <= `RST_PORT_C;
            dir_a_q           <= `RST_BYTE;
            dir_b_q           <= `RST_WORD7;
            counter_latch     <= 16'h0000;
            aux_control       <= `RST_BYTE;
            periph_control    <= `RST_BYTE;
            irq_enable        <= `RST_WORD7;
            serial_write_data <= `RST_BYTE;
            flag_clear_mask   <= `RST_WORD7;
        end else if (clk_en) begin
            if (in_reset) begin
                port_a_q          <= `RST_BYTE;
                port_b_q          <= `RST_WORD7;
                port_c_q          <= `RST_PORT_C;
                dir_a_q           <= `RST_BYTE;
                dir_b_q           <= `RST_WORD7;
                counter_latch     <= 16'h0000;
                aux_control       <= `RST_BYTE;
                periph_control    <= `RST_BYTE;
                irq_enable        <= `RST_WORD7;
                flag_clear_mask   <= `RST_WORD7;
            end else if (wr_io) begin
                // Write side of the I/O function table
                case (io_fn)
                    `IO_PORT_A:      port_a_q <= data_in;
                    `IO_PORT_B:      port_b_q <= data_in[6:0];
                    `IO_PORT_C:      port_c_q <= data_in;
                    `IO_CNT_LO:      counter_latch[7:0]  <= data_in;
                    `IO_CNT_HI:      counter_latch[15:8] <= data_in;
                    `IO_LATCH_LO:    counter_latch[7:0]  <= data_in;
                    `IO_LATCH_HI:    counter_latch[15:8] <= data_in;
                    `IO_SERIAL:      serial_write_data <= data_in;
                    `IO_IRQ_FLAG:    flag_clear_mask <= data_in[6:0];
                    `IO_IRQ_ENABLE:  irq_enable <= data_in[6:0];
                    `IO_AUX_CTRL:    aux_control <= data_in;
                    `IO_PERIPH_CTRL: periph_control <= data_in;
                    `IO_DIR_A:       dir_a_q <= data_in;
                    `IO_DIR_B:       dir_b_q <= data_in[6:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    // One-cycle side-effect strobes; reads of write-only slots raise none
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            counter_load      <= 1'b0;
            serial_write      <= 1'b0;
            flag_clear        <= 1'b0;
            port_a_access     <= 1'b0;
            serial_access     <= 1'b0;
            counter_lo_read   <= 1'b0;
            upper_latch_write <= 1'b0;
        end else if (clk_en) begin
            counter_load      <= wr_io & is_fn(io_fn, `IO_CNT_HI);
            serial_write      <= wr_io & is_fn(io_fn, `IO_SERIAL);
            flag_clear        <= wr_io & is_fn(io_fn, `IO_IRQ_FLAG);
            port_a_access     <= (wr_io | rd_io) & is_fn(io_fn, `IO_PORT_A);
            serial_access     <= (wr_io | rd_io) & is_fn(io_fn, `IO_SERIAL);
            counter_lo_read   <= rd_io & is_fn(io_fn, `IO_CNT_LO);
            upper_latch_write <= wr_io & (is_fn(io_fn, `IO_CNT_HI) |
                                          is_fn(io_fn, `IO_LATCH_HI));
        end
    end

    // Pin read value: outputs read back latch, inputs read the pin
    wire [7:0] pa_read = (port_a_q & dir_a_q) | (pa_q & ~dir_a_q);
    wire [6:0] pb_read = (port_b_q[6:0] & dir_b_q) | (pb_q & ~dir_b_q);

    // Read mux, registered so data comes from flip-flops
    reg [7:0] rd_d;
    always @* begin
        rd_d = 8'h00;
        if (rom_hit) begin
            rd_d = rom_data;
        end else if (ram_hit) begin
            rd_d = ram_mem[addr[6:0]];
        end else if (io_hit) begin
            case (io_fn)
                `IO_PORT_A:      rd_d = pa_read;
                `IO_PORT_B:      rd_d = {1'b0, pb_read};
                `IO_CNT_LO:      rd_d = counter_value[7:0];
                `IO_CNT_HI:      rd_d = counter_value[15:8];
                `IO_SERIAL:      rd_d = serial_read_data;
                `IO_IRQ_FLAG:    rd_d = {irq_pending, irq_flag_value};
                `IO_IRQ_ENABLE:  rd_d = {1'b0, irq_enable};
                `IO_AUX_CTRL:    rd_d = aux_control;
                `IO_PERIPH_CTRL: rd_d = periph_control;
                default:         rd_d = 8'h00;
            endcase
        end
    end

    reg rd_act_q;
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            data_out <= 8'h00;
            rd_act_q <= 1'b0;
        end else if (clk_en) begin
            data_out <= rd_d;
            rd_act_q <= read_not_write & (rom_hit | ram_hit | io_hit) & ~in_reset;
        end
    end

    // Bus drivers on only for a selected read
    assign data_oe = rd_act_q;

    // Port drivers; select lines and interrupt line handled apart
    wire irq_line_used = periph_control[0];
    wire [6:0] cs_mask = {1'b0, CS_USE[1], CS_USE[0], 4'h0};
    wire [6:0] irq_mask = {irq_line_used, 6'h00};

    assign first_port_lines_out = port_a_q;
    assign first_port_lines_oe  = dir_a_q;
    // Interrupt line only pulls low, so it can share a pull-up with others
    assign second_port_lines_out = port_b_q[6:0] & ~irq_mask;
    assign second_port_lines_oe  = (dir_b_q & ~cs_mask & ~irq_mask) |
                                   (irq_mask & {irq_pending, 6'h00});
    assign output_only_lines = port_c_q;

endmodule

// file: test/host_bus_model.sv
// Purpose: host processor side of the byte bus and initialise pin
// Assumes: requests set after a falling edge, taken at the next rising edge
// Notes:   released bus shows an idle address and inverted data, never stale values
`timescale 1ns/1ps

module host_bus_model (
    input  wire         ref_clk,
    input  wire  [7:0]  data_out,
    input  wire         data_oe,
    output logic [11:0] addr,
    output logic        read_not_write,
    output logic [7:0]  data_in,
    output logic        init_low_input_n
);
    // Idle address hits no area
    initial begin
        addr = 12'h400;
        read_not_write = 1'b1;
        data_in = 8'h00;
        init_low_input_n = 1'b1;
    end

    // One transfer; answer taken one edge after the request edge
    task automatic access(input logic [11:0] a, input logic rnw, input logic [7:0] d,
                          output logic [7:0] rd, output logic oe);
        @(negedge ref_clk);
        addr = a;
        read_not_write = rnw;
        data_in = rnw ? ~d : d;
        @(negedge ref_clk);
        rd = data_out;
        oe = data_oe;
        addr = 12'h400;
        read_not_write = 1'b1;
        data_in = ~data_in;
    endtask

    // Pin held low well past four periods, sync delay included
    task automatic init_pulse();
        @(negedge ref_clk);
        init_low_input_n = 1'b0;
        repeat (9) @(negedge ref_clk);
        init_low_input_n = 1'b1;
        repeat (8) @(negedge ref_clk);
    endtask
endmodule

// file: test/rom_ram_io_bus_decode_checker.sv
// Purpose: concurrent checks on the bus decoder ports
// Assumes: masked variant, chip selects unused, one clock domain
// Notes:   writes counted only after the initialise pin settles
`timescale 1ns/1ps

module rom_ram_io_bus_decode_checker (
    input wire        ref_clk,
    input wire        arst_n,
    input wire        clk_en,
    input wire        init_low_input_n,
    input wire [11:0] addr,
    input wire        read_not_write,
    input wire [7:0]  data_in,
    input wire [7:0]  data_out,
    input wire        data_oe,
    input wire [7:0]  first_port_lines_oe,
    input wire [6:0]  second_port_lines_out,
    input wire [6:0]  second_port_lines_oe,
    input wire [7:0]  output_only_lines,
    input wire        counter_load,
    input wire [15:0] counter_latch,
    input wire        port_a_access,
    input wire        counter_lo_read,
    input wire        serial_write,
    input wire [7:0]  aux_control,
    input wire [7:0]  periph_control,
    input wire        rom_sel,
    input wire [10:0] rom_addr
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    // Settle count; sync stages hide writes just after the pin rises
    logic [2:0] run_q;
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) run_q <= 3'h0;
        else if (!init_low_input_n) run_q <= 3'h0;
        else if (run_q != 3'h7) run_q <= run_q + 3'h1;
    end

    // Area decode of the masked variant
    wire io   = addr[11:4] == 8'h70;
    wire hit  = addr[11] || addr[11:7] == 5'h00 || io;
    wire go   = clk_en && init_low_input_n && run_q == 3'h7;
    wire wr   = go && io && !read_not_write;
    wire rd   = go && io && read_not_write;
    wire strb = counter_load || serial_write || port_a_access || counter_lo_read;
    wire undef = addr[3:0] inside {4'h2, 4'h3, 4'h6, 4'h7, 4'hD, 4'hE, 4'hF};

    bus_oe_a: assert property (data_oe |-> $past(read_not_write) && $past(hit))
        else $error("data bus driven outside a read");
    rom_map_a: assert property (rom_addr == addr[10:0] && (!rom_sel || addr[11]))
        else $error("rom select or byte address wrong");
    arst_fill_a: assert property ($rose(arst_n) |-> output_only_lines == 8'hFF
        && first_port_lines_oe == 8'h00 && second_port_lines_oe == 7'h00)
        else $error("port state wrong after reset");
    init_clear_a: assert property (!init_low_input_n [*8] |-> output_only_lines == 8'hFF
        && aux_control == 8'h00 && periph_control == 8'h00 && counter_latch == 16'h0000)
        else $error("registers not cleared by initialise pin");
    dir_a_a: assert property (wr && addr[3:0] == 4'hD |=>
        first_port_lines_oe == $past(data_in))
        else $error("port a direction not written");
    port_c_a: assert property (wr && addr[3:0] == 4'h2 |=>
        output_only_lines == $past(data_in))
        else $error("output only port not written");
    load_a: assert property (wr && addr[3:0] == 4'h5 |=>
        counter_latch[15:8] == $past(data_in) ##[0:1] counter_load)
        else $error("upper latch write or load missing");
    drain_a: assert property (periph_control[0] |->
        !(second_port_lines_oe[6] && second_port_lines_out[6]))
        else $error("interrupt line driven high");
    undef_a: assert property (rd && undef |=> data_out == 8'h00 && !strb ##1 !strb)
        else $error("side effect of undefined read");
    pcr_rd_a: assert property (rd && addr[3:0] == 4'hC |=>
        data_oe && data_out == $past(periph_control))
        else $error("control register read wrong");

    // Main scenarios reached
    cover property (wr && addr[3:0] == 4'h5);
    cover property (go && addr[11] && read_not_write);
    cover property (periph_control[0] && second_port_lines_oe[6]);
endmodule

bind rom_ram_io_bus_decode rom_ram_io_bus_decode_checker u_rom_ram_io_bus_decode_checker (
    .ref_clk, .arst_n, .clk_en, .init_low_input_n, .addr, .read_not_write, .data_in,
    .data_out, .data_oe, .first_port_lines_oe, .second_port_lines_out,
    .second_port_lines_oe, .output_only_lines, .counter_load, .counter_latch,
    .port_a_access, .counter_lo_read, .serial_write, .aux_control, .periph_control,
    .rom_sel, .rom_addr);

// file: test/tb.sv
// Purpose: self-checking bench for the bus decoder, masked variant
// Assumes: inputs change at falling edges; host model owns the bus
// Notes:   table rows write then read back; reset cases follow
`timescale 1ns/1ps

module tb;
    logic        ref_clk, arst_n, clk_en, init_low_input_n, read_not_write, data_oe;
    logic        irq_pending, counter_load, serial_write, flag_clear, port_a_access;
    logic        serial_access, counter_lo_read, upper_latch_write, rom_sel, oe;
    logic [7:0]  data_in, data_out, first_port_lines_in, first_port_lines_out;
    logic [7:0]  first_port_lines_oe, output_only_lines, serial_read_data, rd;
    logic [7:0]  serial_write_data, aux_control, periph_control, rom_data;
    logic [6:0]  second_port_lines_in, second_port_lines_out, second_port_lines_oe;
    logic [6:0]  irq_flag_value, flag_clear_mask, irq_enable;
    logic [3:0]  input_only_lines, input_only_sync;
    logic [11:0] addr;
    logic [10:0] rom_addr;
    logic [15:0] counter_value, counter_latch;
    logic [1:0]  b6;
    int          fail_count, samples_checked, cycles;

    // Address, data written, value read back
    localparam logic [27:0] ROWS [14] = '{
        {12'h70D, 8'hF0, 8'h00}, {12'h700, 8'hA5, 8'hAC}, {12'h70B, 8'h5A, 8'h5A},
        {12'h70C, 8'h3C, 8'h3C}, {12'h008, 8'hC3, 8'hC3}, {12'h07F, 8'h81, 8'h81},
        {12'hABC, 8'h00, 8'h43}, {12'h704, 8'h12, 8'hEF}, {12'h705, 8'h34, 8'hBE},
        {12'h708, 8'h99, 8'h6D}, {12'h709, 8'h00, 8'hAB}, {12'h702, 8'h3C, 8'h00},
        {12'h703, 8'h0F, 8'h00}, {12'h70F, 8'h55, 8'h00}};

    rom_ram_io_bus_decode u_rom_ram_io_bus_decode (
        .ref_clk, .arst_n, .clk_en, .init_low_input_n, .addr, .read_not_write, .data_in,
        .data_out, .data_oe, .first_port_lines_in, .first_port_lines_out,
        .first_port_lines_oe, .second_port_lines_in, .second_port_lines_out,
        .second_port_lines_oe, .output_only_lines, .input_only_lines, .irq_pending,
        .counter_value, .serial_read_data, .irq_flag_value, .counter_load,
        .counter_latch, .serial_write, .serial_write_data, .flag_clear, .flag_clear_mask,
        .port_a_access, .serial_access, .counter_lo_read, .upper_latch_write,
        .aux_control, .periph_control, .irq_enable, .rom_sel, .rom_addr, .rom_data,
        .input_only_sync);

    host_bus_model u_host_bus_model (
        .ref_clk, .data_out, .data_oe, .addr, .read_not_write, .data_in, .init_low_input_n);

    // ROM contents follow the low eight address bits so each byte within 256 is distinct
    assign rom_data = ~rom_addr[7:0];

    // Line b6 enable beside its level, so one compare sees both
    assign b6 = {second_port_lines_oe[6], second_port_lines_out[6]};

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Hang guard, well above the expected run
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            end_sim();
        end
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic bus(input logic [11:0] a, input logic rnw, input logic [7:0] d);
        u_host_bus_model.access(a, rnw, d, rd, oe);
    endtask

    // State every reset must leave
    task automatic check_cleared();
        check("port c", {8'h00, output_only_lines}, 16'h00FF);
        check("port dirs", {1'b0, first_port_lines_oe, second_port_lines_oe}, 16'h0000);
        check("controls", {aux_control, periph_control}, 16'h0000);
        check("irq enable", {9'h000, irq_enable}, 16'h0000);
        check("latch", counter_latch, 16'h0000);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        fail_count = 0;
        samples_checked = 0;
        cycles = 0;
        arst_n = 1'b0;
        clk_en = 1'b1;
        irq_pending = 1'b1;
        first_port_lines_in = 8'h3C;
        second_port_lines_in = 7'h2A;
        input_only_lines = 4'h9;
        counter_value = 16'hBEEF;
        serial_read_data = 8'h6D;
        irq_flag_value = 7'h2B;
        repeat (2) @(negedge ref_clk);
        arst_n = 1'b1;
        repeat (8) @(negedge ref_clk);
        check_cleared();
        $display("test reset state done");
        // Table of write then read back
        for (int i = 0; i < 14; i++) begin
            bus(ROWS[i][27:16], 1'b0, ROWS[i][15:8]);
            check("write oe", {15'h0000, oe}, 16'h0000);
            bus(ROWS[i][27:16], 1'b1, 8'h00);
            check("read data", {8'h00, rd}, {8'h00, ROWS[i][7:0]});
        end
        check("latch", counter_latch, 16'h3412);
        check("port c", {8'h00, output_only_lines}, 16'h003C);
        check("pa", {first_port_lines_oe, first_port_lines_out[7:4], 4'h0}, 16'hF0A0);
        // Strobes stand for the cycle after the access, still high on return
        bus(12'h708, 1'b0, 8'h5C);
        check("serial wr", {7'h00, serial_write, serial_write_data}, 16'h015C);
        check("serial acc", {15'h0000, serial_access}, 16'h0001);
        bus(12'h709, 1'b0, 8'h7F);
        check("flag clr", {8'h00, flag_clear, flag_clear_mask}, 16'h00FF);
        bus(12'h707, 1'b0, 8'h56);
        check("upper latch", {14'h0000, upper_latch_write, counter_load}, 16'h0002);
        bus(12'h704, 1'b1, 8'h00);
        check("low read", {14'h0000, counter_lo_read, port_a_access}, 16'h0002);
        check("port d", {12'h000, input_only_sync}, 16'h0009);
        $display("test table done");
        // Line b6 push-pull, then open drain as interrupt output
        bus(12'h70E, 1'b0, 8'h40);
        bus(12'h701, 1'b0, 8'h40);
        bus(12'h70C, 1'b0, 8'h00);
        check("b6 push pull", {14'h0000, b6}, 16'h0003);
        bus(12'h70C, 1'b0, 8'h01);
        check("b6 pull low", {14'h0000, b6}, 16'h0002);
        irq_pending = 1'b0;
        @(negedge ref_clk);
        check("b6 released", {14'h0000, b6}, 16'h0000);
        irq_pending = 1'b1;
        $display("test open drain done");
        // Initialise pin clears registers, RAM survives
        u_host_bus_model.init_pulse();
        check_cleared();
        bus(12'h008, 1'b1, 8'h00);
        check("ram kept", {8'h00, rd}, 16'h00C3);
        // Reset in mid-run after dirtying state
        bus(12'h70B, 1'b0, 8'h77);
        @(negedge ref_clk);
        arst_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        arst_n = 1'b1;
        repeat (8) @(negedge ref_clk);
        check_cleared();
        $display("test resets done");
        end_sim();
    end
endmodule
